/* common/tbg_params.svh */
/*
  Constants of the transmit block gearbox: register offsets, field
  positions, reset values and buffer sizes.
  Assumes it is included by bare name, once per compile unit or more.
*/
`ifndef TBG_PARAMS_SVH
`define TBG_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Coding configuration register, one per channel
`define TBG_CFG_OFS_CH0      16'h0C77
`define TBG_CFG_OFS_CH1      16'h0D77
`define TBG_CFG_OFS_CH2      16'h0E77
`define TBG_CFG_OFS_CH3      16'h0F77
`define TBG_CFG_ENABLE_BIT   5
`define TBG_CFG_ASYNC_BIT    4
`define TBG_CFG_RSVD_HI      3
`define TBG_CFG_RSVD_LO      1
`define TBG_CFG_FMT66_BIT    0

////////////////////////////////////////////////////////////////////////////
// Crossing status register and its flags
`define TBG_STAT_OFS_CH0     16'h0861
`define TBG_STAT_OFS_CH1     16'h0961
`define TBG_STAT_OFS_CH2     16'h0A61
`define TBG_STAT_OFS_CH3     16'h0B61
`define TBG_STAT_OVR_BIT     24
`define TBG_STAT_UNR_BIT     25

////////////////////////////////////////////////////////////////////////////
// Header input fields
`define TBG_HDR0_LO          0
`define TBG_HDR1_LO          3
`define TBG_HDR66_LEN        7'h02
`define TBG_HDR67_LEN        7'h03
`define TBG_SEQ_SLOT_BIT     0

////////////////////////////////////////////////////////////////////////////
// Widths of the datapath
`define TBG_PAY_W            128
`define TBG_HDR_W            6
`define TBG_SEQ_W            7
`define TBG_OUT_W            64
`define TBG_BUF_W            256
`define TBG_CNT_W            9
`define TBG_NEW_W            160

////////////////////////////////////////////////////////////////////////////
// Reset values
`define TBG_RST_CNT          9'h000
`define TBG_RST_WORD         64'h0000_0000_0000_0000

`endif

/* common/tbg_pkg.sv */
/*
  Types of the transmit block gearbox: width codes and the state record.
  Assumes tbg_params.svh sits on the include path.
*/
`include "tbg_params.svh"

package tbg_pkg;

  // Fabric interface width code
  typedef enum logic [1:0] {
    TBG_IF_2B  = 2'h0,
    TBG_IF_4B  = 2'h1,
    TBG_IF_8B  = 2'h2,
    TBG_IF_16B = 2'h3
  } tbg_ifw_t;

  // Whole state of the gearbox, registered in one place
  typedef struct packed {
    logic                      fclk_s1;
    logic                      fclk_s2;
    logic                      fclk_d;
    logic                      lclk_s1;
    logic                      lclk_s2;
    logic                      lclk_d;
    logic [`TBG_HDR_W-1:0]     hdr_s1;
    logic [`TBG_HDR_W-1:0]     hdr_s2;
    logic [`TBG_SEQ_W-1:0]     seq_s1;
    logic [`TBG_SEQ_W-1:0]     seq_s2;
    logic [`TBG_PAY_W-1:0]     pay_s1;
    logic [`TBG_PAY_W-1:0]     pay_s2;
    logic [`TBG_BUF_W-1:0]     bits;
    logic [`TBG_CNT_W-1:0]     cnt;
    logic [`TBG_OUT_W-1:0]     word;
    logic                      word_vld;
    logic                      ovr;
    logic                      unr;
  } tbg_state_t;

endpackage : tbg_pkg

/* hdl/tbg_tx_gearbox.sv */
/*
  Transmit block gearbox for one channel: merges block headers with
  scrambled payload and packs them into the line-side word.
  Assumes the configuration word is static while the channel runs, and
  that the fabric and line-side clocks are slow compared with core_clk.
*/
//
// Contract
// R1: Software sets the enable bit before operation.
// R2: Mode bit 4 picks synchronous or asynchronous.
// R3: Software writes zero to reserved mode bits.
// R4: Mode bit 0 picks 67-bit or 66-bit framing.
// R5: Synchronous mode takes 2, 4, 8-byte words.
// R6: Fabric scrambles payload; gearbox never scrambles.
// R7: Four-byte first cycle: header then 30 bits.
// R8: Next cycle: 2 leftover bits, 30 new.
// R9: Third cycle: 2 bits, header, 28 bits.
// R10: Header bit 0 is transmitted first.
// R11: Headers from bits 1:0, and 4:3 if 16-byte.
// R12: Slot bit low marks a valid header.
// R13: Wide interfaces hold slot bit low always.
// R14: Four-byte interface toggles slot bit every cycle.
// R15: Asynchronous mode supports 66-bit framing only.
// R16: Asynchronous: 4/8/16-byte words, 4/8-byte datapath.
// R17: Asynchronous width pairings use fixed clock ratios.
// R18: Asynchronous mode accepts a word every cycle.
// R19: Synchronous fabric pauses on marked sequence counts.
// R20: Software configures buffer bypass for asynchronous mode.
// R21: Four-byte datapath emits 32 bits per edge.
// R22: Eight-byte datapath emits 64, takes 66 bits.
// R23: Sticky flags report crossing overrun and underrun.
// R24: Crossing buffer keeps header and payload order.
// R25: Reset clears slip state and alignment.
`timescale 1ns/1ps
`include "tbg_params.svh"

module tbg_tx_gearbox (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  // Configuration register and width straps
  input  wire logic [31:0]             tx_coding_config,
  input  wire logic [1:0]              iface_width_sel,
  input  wire logic                    int_width_8b,
  // Fabric side, sampled on the fabric clock
  input  wire logic                    fabric_tx_clock,
  input  wire logic [`TBG_HDR_W-1:0]   header_bits_in,
  input  wire logic [`TBG_SEQ_W-1:0]   header_slot_seq,
  input  wire logic [`TBG_PAY_W-1:0]   payload_word_in,
  // Line side
  input  wire logic                    line_side_clk,
  output logic [`TBG_OUT_W-1:0]        line_word_out,
  output logic                         line_word_valid,
  // Crossing status
  output logic                         crossing_overrun_flag,
  output logic                         crossing_underrun_flag
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Bits in one fabric word for a width code
  function automatic logic [7:0] tbg_if_bits(input logic [1:0] sel);
    logic [7:0] n;
    n = 8'h10;
    unique case (tbg_pkg::tbg_ifw_t'(sel))
      tbg_pkg::TBG_IF_2B:  n = 8'h10;
      tbg_pkg::TBG_IF_4B:  n = 8'h20;
      tbg_pkg::TBG_IF_8B:  n = 8'h40;
      tbg_pkg::TBG_IF_16B: n = 8'h80;
    endcase
    return n;
  endfunction : tbg_if_bits

  // Low n bits set, n up to 64; a shift by 64 yields zero, so the mask is all ones
  function automatic logic [63:0] tbg_low_mask(input logic [6:0] n);
    logic [63:0] m;
    m = ~(64'hFFFF_FFFF_FFFF_FFFF << n);
    return m;
  endfunction : tbg_low_mask

  ////////////////////////////////////////////////////////////////////////
  // Configuration decode

  logic       gb_on;
  logic       mode_async;
  logic       fmt_66;
  logic       cfg_legal;
  logic [6:0] hdr_len;
  logic [7:0] in_bits;
  logic [6:0] out_bits;

  always_comb begin
    gb_on      = tx_coding_config[`TBG_CFG_ENABLE_BIT];
    mode_async = tx_coding_config[`TBG_CFG_ASYNC_BIT];        // see R2
    fmt_66     = tx_coding_config[`TBG_CFG_FMT66_BIT];        // see R4
    hdr_len    = fmt_66 ? `TBG_HDR66_LEN : `TBG_HDR67_LEN;    // see R4
    in_bits    = tbg_if_bits(iface_width_sel);
    // Async datapath is 4 or 8 bytes; sync output matches the fabric word
    if (mode_async) begin
      out_bits = int_width_8b ? 7'h40 : 7'h20;                // see R21
    end else begin
      out_bits = in_bits[6:0];
    end
    // Illegal pairings leave the gearbox idle rather than emit junk
    if (mode_async) begin
      cfg_legal = fmt_66 &&                                   // see R15
                  (iface_width_sel != 2'h0) &&                // see R16
                  !(int_width_8b && iface_width_sel == 2'h1) &&
                  !(!int_width_8b && iface_width_sel == 2'h3);
    end else begin
      cfg_legal = (iface_width_sel != 2'h3);                  // see R5
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State

  tbg_pkg::tbg_state_t st_reg;
  tbg_pkg::tbg_state_t st_next;

  // Working variables of the next-state logic
  logic                   active;
  logic                   take;
  logic                   emit;
  logic                   slot;
  logic [6:0]             lo_bits;
  logic [7:0]             new_len;
  logic [`TBG_NEW_W-1:0]  new_bits;
  logic [63:0]            pay_lo;
  logic [63:0]            pay_hi;
  logic [`TBG_BUF_W-1:0]  buf_v;
  logic [9:0]             cnt_v;
  logic [9:0]             room;

  always_comb begin
    st_next  = st_reg;
    active   = 1'b0;
    take     = 1'b0;
    emit     = 1'b0;
    slot     = 1'b0;
    lo_bits  = 7'h00;
    new_len  = 8'h00;
    new_bits = '0;
    pay_lo   = 64'h0;
    pay_hi   = 64'h0;
    buf_v    = st_reg.bits;
    cnt_v    = {1'b0, st_reg.cnt};
    room     = 10'h000;

    // Two-stage synchronisers; logic reads stage two, and for the clocks also its delayed copy
    st_next.fclk_s1 = fabric_tx_clock;
    st_next.fclk_s2 = st_reg.fclk_s1;
    st_next.fclk_d  = st_reg.fclk_s2;
    st_next.lclk_s1 = line_side_clk;
    st_next.lclk_s2 = st_reg.lclk_s1;
    st_next.lclk_d  = st_reg.lclk_s2;
    st_next.hdr_s1  = header_bits_in;
    st_next.hdr_s2  = st_reg.hdr_s1;
    st_next.seq_s1  = header_slot_seq;
    st_next.seq_s2  = st_reg.seq_s1;
    st_next.pay_s1  = payload_word_in;
    st_next.pay_s2  = st_reg.pay_s1;
    st_next.word_vld = 1'b0;

    active = gb_on && cfg_legal;                              // see R1
    // Fabric words change on the rising edge, so capture mid-period on
    // the falling edge where the synchronised copy is settled
    take = active && st_reg.fclk_d && !st_reg.fclk_s2;
    // Sync mode runs output and input on the same fabric cycle
    if (mode_async) begin
      emit = active && st_reg.lclk_s2 && !st_reg.lclk_d;      // see R17
    end else begin
      emit = take;
    end

    //////////////////////////////////////////////////////////////////////
    // Line side: drain oldest bits first, lowest buffer bit goes first
    if (emit) begin
      if (cnt_v >= {3'h0, out_bits}) begin
        st_next.word     = st_reg.bits[63:0] & tbg_low_mask(out_bits);
        st_next.word_vld = 1'b1;                              // see R21 R22
        buf_v            = st_reg.bits >> out_bits;
        cnt_v            = cnt_v - {3'h0, out_bits};
      end else if (mode_async) begin
        st_next.unr = 1'b1;                                   // see R23
      end
    end

    //////////////////////////////////////////////////////////////////////
    // Fabric side: header (bit 0 first), then payload from bit 0
    if (take) begin
      slot    = !st_reg.seq_s2[`TBG_SEQ_SLOT_BIT];            // see R12
      lo_bits = (in_bits > 8'h40) ? 7'h40 : in_bits[6:0];
      pay_lo  = st_reg.pay_s2[63:0] & tbg_low_mask(lo_bits);
      pay_hi  = st_reg.pay_s2[127:64];
      if (slot) begin
        new_bits = `TBG_NEW_W'(st_reg.hdr_s2[`TBG_HDR0_LO +: 3]
                   & 3'(tbg_low_mask(hdr_len)));              // see R10 R11
        new_len  = {1'b0, hdr_len};
      end
      new_bits = new_bits | (`TBG_NEW_W'(pay_lo) << new_len); // see R7 R8
      new_len  = new_len + {1'b0, lo_bits};
      if (iface_width_sel == 2'h3) begin
        if (slot) begin
          new_bits = new_bits |
                     (`TBG_NEW_W'(st_reg.hdr_s2[`TBG_HDR1_LO +: 2])
                      << new_len);                            // see R11
          new_len  = new_len + {1'b0, hdr_len};
        end
        new_bits = new_bits | (`TBG_NEW_W'(pay_hi) << new_len);
        new_len  = new_len + 8'h40;
      end
      // Append behind whatever is still queued, so the offset slips
      room = 10'(`TBG_BUF_W) - cnt_v;
      if ({2'h0, new_len} <= room) begin
        buf_v = buf_v | (`TBG_BUF_W'(new_bits) << cnt_v);     // see R9 R24
        cnt_v = cnt_v + {2'h0, new_len};                      // see R18
      end else if (mode_async) begin
        // Word is dropped whole so later blocks stay aligned
        st_next.ovr = 1'b1;                                   // see R23
      end
    end

    st_next.bits = buf_v;
    st_next.cnt  = cnt_v[`TBG_CNT_W-1:0];

    // A disabled gearbox holds no queued bits for its next start
    if (!active) begin
      st_next.bits = '0;
      st_next.cnt  = `TBG_RST_CNT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_reg          <= '0;                                  // see R25
      st_reg.cnt      <= `TBG_RST_CNT;
      st_reg.word     <= `TBG_RST_WORD;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops

  always_comb begin
    line_word_out          = st_reg.word;
    line_word_valid        = st_reg.word_vld;
    crossing_overrun_flag  = st_reg.ovr;
    crossing_underrun_flag = st_reg.unr;
  end

endmodule : tbg_tx_gearbox

/* test/tbg_gearbox_checker.sv */
/*
  Port checker for the transmit gearbox, bound to its top module.
  Assumes a static configuration word while out of reset.
*/
`timescale 1ns/1ps
`include "tbg_params.svh"
module tbg_gearbox_checker (
  // Clock, reset and setup
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic [31:0]           tx_coding_config,
  input wire logic [1:0]            iface_width_sel,
  input wire logic                  int_width_8b,
  // Line side
  input wire logic                  line_side_clk,
  input wire logic [`TBG_OUT_W-1:0] line_word_out,
  input wire logic                  line_word_valid,
  input wire logic                  crossing_overrun_flag,
  input wire logic                  crossing_underrun_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic en_async;
  assign en_async = tx_coding_config[5:0] == 6'h31 && (int_width_8b ?
    iface_width_sel[1] : iface_width_sel[0] ^ iface_width_sel[1]);
  ////////////////////////////////////////////////////////////////////////
  sequence line_rise_s;
    $rose(line_side_clk) && en_async;
  endsequence
  sequence word_out_s;
    line_word_valid || crossing_underrun_flag;
  endsequence
  AST_LINE_ANSWER: assert property (line_rise_s |-> ##[2:6] word_out_s)
    else $error("no word after line clock edge");
  AST_VALID_ONE: assert property (line_word_valid |=> !line_word_valid)
    else $error("valid longer than one cycle");
  AST_OFF_QUIET: assert property (!tx_coding_config[5] [*3] |-> !line_word_valid)
    else $error("word emitted while disabled");
  AST_NO_ASYNC67: assert property ((tx_coding_config[5:4] == 2'h3
    && !tx_coding_config[0]) [*3] |-> !line_word_valid)
    else $error("word emitted in async 67-bit mode");
  AST_OVR_STICKY: assert property (crossing_overrun_flag |=> crossing_overrun_flag)
    else $error("overrun flag dropped");
  AST_UNR_STICKY: assert property ($rose(crossing_underrun_flag) |->
    crossing_underrun_flag [*4])
    else $error("underrun flag dropped");
  AST_RESET_CLEAR: assert property ($fell(sys_rst) |-> !line_word_valid
    && line_word_out == '0 && !crossing_overrun_flag && !crossing_underrun_flag)
    else $error("state not cleared by reset");
  AST_NARROW_ZERO: assert property (line_word_valid && (tx_coding_config[4] ?
    !int_width_8b : iface_width_sel != 2'h2) |-> line_word_out[63:32] == '0)
    else $error("upper half set on narrow word");
  AST_WORD_HOLDS: assert property (!line_word_valid && tx_coding_config[5]
    && $past(tx_coding_config[5]) |-> $stable(line_word_out))
    else $error("word changed without valid");
endmodule : tbg_gearbox_checker

bind tbg_tx_gearbox tbg_gearbox_checker i_tbg_gearbox_checker (
  .core_clk(core_clk), .sys_rst(sys_rst), .tx_coding_config(tx_coding_config),
  .iface_width_sel(iface_width_sel), .int_width_8b(int_width_8b),
  .line_side_clk(line_side_clk), .line_word_out(line_word_out),
  .line_word_valid(line_word_valid),
  .crossing_overrun_flag(crossing_overrun_flag),
  .crossing_underrun_flag(crossing_underrun_flag));

/* test/tbg_fabric_model.sv */
/*
  Fabric-side model: scrambled payload words and headers on its own clock.
  Assumes the testbench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`include "tbg_params.svh"
module tbg_fabric_model (
  // Fabric clock and words
  output logic                  fabric_tx_clock,
  output logic [`TBG_HDR_W-1:0] header_bits_in,
  output logic [`TBG_SEQ_W-1:0] header_slot_seq,
  output logic [`TBG_PAY_W-1:0] payload_word_in
);
  initial begin
    fabric_tx_clock = 1'b0;
    header_bits_in  = 6'h00;
    header_slot_seq = 7'h01;
    payload_word_in = '0;
  end
  // One fabric cycle; the clock stands low between frames
  task automatic cyc(input logic [1:0] h, input logic s, input logic [63:0] p,
                     input int half);
    header_bits_in  = {4'h0, h};
    header_slot_seq = {6'h00, s};
    payload_word_in = {~p, p};
    fabric_tx_clock = 1'b1;
    #(half);
    fabric_tx_clock = 1'b0;
    #(half);
  endtask : cyc
  // One block; payload already scrambled, upper lanes carry junk
  task automatic send(input logic [1:0] h, input logic [63:0] p,
                      input logic narrow, input int half);
    if (narrow) begin
      cyc(h, 1'b0, {~p[63:32], p[31:0]}, half);
      cyc(~h, 1'b1, {~p[31:0], p[63:32]}, half);
    end else begin
      cyc(h, 1'b0, p, half);
    end
  endtask : send
  // Released lines show the inverse so stale data cannot pass
  task automatic release_bus();
    header_bits_in  = ~header_bits_in;
    header_slot_seq = ~header_slot_seq;
    payload_word_in = ~payload_word_in;
  endtask : release_bus
endmodule : tbg_fabric_model

/* test/testbench.sv */
/*
  Testbench: sync and async packing, refused modes, overrun, underrun.
  Assumes the gearbox, its checker and the fabric model.
*/
`timescale 1ns/1ps
module testbench;
  logic         core_clk = 1'b0;
  logic         sys_rst  = 1'b1;
  logic [31:0]  cfg      = 32'h0;
  logic [1:0]   ifw      = 2'h0;
  logic         int8     = 1'b0;
  logic         line_clk = 1'b0;
  logic         line_run = 1'b0;
  logic         fclk, vld, ovr, unr;
  logic [5:0]   hdr;
  logic [6:0]   seq;
  logic [127:0] pay;
  logic [63:0]  word;
  logic         stream[$];
  logic [63:0]  got[$];
  int           mismatches = 0;
  int           check_count = 0;
  always #20 core_clk = ~core_clk;
  // Line clock stands still outside frames
  always #160 line_clk = line_run ? ~line_clk : 1'b0;
  tbg_tx_gearbox i_tbg_tx_gearbox (.core_clk(core_clk), .sys_rst(sys_rst),
    .tx_coding_config(cfg), .iface_width_sel(ifw), .int_width_8b(int8),
    .fabric_tx_clock(fclk), .header_bits_in(hdr), .header_slot_seq(seq),
    .payload_word_in(pay), .line_side_clk(line_clk), .line_word_out(word),
    .line_word_valid(vld), .crossing_overrun_flag(ovr),
    .crossing_underrun_flag(unr));
  tbg_fabric_model i_tbg_fabric_model (.fabric_tx_clock(fclk),
    .header_bits_in(hdr), .header_slot_seq(seq), .payload_word_in(pay));
  // Sampled mid-cycle, clear of the edge that launches the word
  always @(negedge core_clk) if (vld === 1'b1) got.push_back(word);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [63:0] exp, input logic [63:0] act);
    check_count++;
    if (act !== exp) begin
      mismatches++;
      $display("[ERR] %0t exp %h got %h", $time, exp, act);
    end
  endtask : chk_word
  task automatic chk_bit(input logic exp, input logic act);
    chk_word({63'h0, exp}, {63'h0, act});
  endtask : chk_bit
  // Expected words are the block stream cut into line-width slices
  task automatic chk_words(input int n, input int w);
    logic [63:0] e;
    for (int k = 0; k < n; k++) begin
      e = '0;
      for (int i = 0; i < w; i++) e[i] = stream.pop_front();
      chk_word(e, (k < got.size()) ? got[k] : 64'hX);
    end
  endtask : chk_words
  task automatic start(input logic [31:0] c, input logic [1:0] w,
                       input logic i8);
    @(negedge core_clk);
    sys_rst = 1'b1;
    cfg = c;
    ifw = w;
    int8 = i8;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    got.delete();
    stream.delete();
    repeat (4) @(negedge core_clk);
  endtask : start
  // Sends n blocks, starting the line clock before block line_at
  task automatic run(input logic [31:0] c, input logic [1:0] w,
                     input logic i8, input logic nar, input int half,
                     input int n, input int line_at);
    logic [1:0]  h;
    logic [63:0] p;
    start(c, w, i8);
    for (int k = 0; k < n; k++) begin
      h = k[0] ? 2'h2 : 2'h1;
      p = 64'h0F1E_2D3C_4B5A_6978 * (k + 3);
      if (k == line_at) line_run = 1'b1;
      // 67-bit framing sends a third header bit, driven low here
      for (int i = 0; i < (c[0] ? 2 : 3); i++)
        stream.push_back((i < 2) ? h[i] : 1'b0);
      for (int i = 0; i < 64; i++) stream.push_back(p[i]);
      i_tbg_fabric_model.send(h, p, nar, half);
    end
    // Sync output lags one fabric cycle; a trailing header cycle drains it
    i_tbg_fabric_model.cyc(2'h1, 1'b0, 64'h0, half);
    i_tbg_fabric_model.release_bus();
    repeat (60) @(negedge core_clk);
    line_run = 1'b0;
  endtask : run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////
  initial begin
    run(32'h21, 2'h1, 1'b0, 1'b1, 160, 2, 99);
    chk_words(4, 32);
    $display("test sync_4byte done");
    run(32'h21, 2'h2, 1'b0, 1'b0, 160, 2, 99);
    chk_words(2, 64);
    $display("test sync_8byte done");
    run(32'h20, 2'h2, 1'b0, 1'b0, 160, 2, 99);
    chk_words(2, 64);
    $display("test sync_67bit done");
    run(32'h31, 2'h2, 1'b1, 1'b0, 165, 4, 2);
    chk_words(4, 64);
    chk_bit(1'b0, ovr);
    chk_bit(1'b1, unr);
    $display("test async_8byte done");
    run(32'h31, 2'h1, 1'b0, 1'b1, 165, 2, 1);
    chk_words(4, 32);
    $display("test async_4byte done");
    run(32'h11, 2'h2, 1'b0, 1'b0, 160, 2, 99);
    chk_word(64'h0, 64'(got.size()));
    run(32'h30, 2'h2, 1'b1, 1'b0, 165, 2, 0);
    chk_word(64'h0, 64'(got.size()));
    $display("test refused done");
    run(32'h31, 2'h2, 1'b1, 1'b0, 165, 5, 99);
    chk_bit(1'b1, ovr);
    start(32'h31, 2'h2, 1'b1);
    chk_bit(1'b0, ovr);
    $display("test overrun done");
    report_and_stop();
  end
  // Whole run takes about 35 us
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule : testbench
